// *** core/fepp_defs.svh ***
// Register map, field positions, reset values and timing of the flash block
`ifndef FEPP_DEFS_SVH
`define FEPP_DEFS_SVH

`define FEPP_REG_ADDR       8'h00
`define FEPP_REG_WDATA      8'h04
`define FEPP_REG_CMD        8'h08
`define FEPP_REG_PLEVEL     8'h0c
`define FEPP_REG_USEC       8'h10
`define FEPP_REG_INTRAW     8'h14
`define FEPP_REG_INTMSK     8'h18
`define FEPP_REG_INTEN      8'h1c
`define FEPP_REG_INTCLR     8'h20

`define FEPP_CMD_PROG       0
`define FEPP_CMD_ERASE      1
`define FEPP_CMD_PSET       2
`define FEPP_CMD_PSAVE      3

`define FEPP_STS_BUSY       0
`define FEPP_STS_FAIL       1

`define FEPP_INT_DONE       0
`define FEPP_INT_ACCESS     1

`define FEPP_USEC_RST       8'h01
`define FEPP_PROG_TIME_US   8'h02
`define FEPP_ERASE_TIME_US  8'h04

`define FEPP_ERASED_WORD    32'hffffffff
`define FEPP_FADDR_W        16
`define FEPP_WORDS          1024
`define FEPP_EBLK_WORDS     256
`define FEPP_NUM_PBLK       2

`endif

// *** core/fepp_pkg.sv ***
// Types shared by the flash erase, program and protection logic
package fepp_pkg;

  typedef enum logic [1:0] {
    prot_level_rw = 2'h0,
    prot_level_ro = 2'h1,
    prot_level_xo = 2'h2
  } fepp_level_t;

  typedef struct packed {
    logic        fetch;
    logic        debug;
    logic [11:0] addr;
  } fepp_rdreq_t;

  typedef struct packed {
    logic access;
    logic done;
  } fepp_ints_t;

endpackage

// *** core/fepp_usec_timer.sv ***
// Microsecond timer paced by the clocks-per-microsecond setting
`timescale 1ns/1ps
module fepp_usec_timer (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       start,
  input  wire logic [7:0] usecs,
  input  wire logic [7:0] clksPerUs,
  output logic            busy,
  output logic            done
);
  logic [7:0] preCnt;
  logic [7:0] usLeft;
  logic       lastTick;

  assign lastTick = (clksPerUs <= 8'h01) || (preCnt == clksPerUs - 8'h01);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy   <= 1'b0;
      done   <= 1'b0;
      preCnt <= 8'h00;
      usLeft <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy   <= 1'b1;
        preCnt <= 8'h00;
        usLeft <= (usecs == 8'h00) ? 8'h01 : usecs;
      end else if (busy) begin
        if (lastTick) begin
          preCnt <= 8'h00;
          usLeft <= usLeft - 8'h01;
          if (usLeft == 8'h01) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end else begin
          preCnt <= preCnt + 8'h01;
        end
      end
    end
  end
endmodule // fepp_usec_timer

// *** core/fepp_prot_cell.sv ***
// Protection level of one 2 kB block: committed part and volatile part
`timescale 1ns/1ps
module fepp_prot_cell (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                nvInitN,
  input  wire logic                setReq,
  input  fepp_pkg::fepp_level_t    newLevel,
  input  wire logic                saveReq,
  output fepp_pkg::fepp_level_t    level,
  output logic                     setOk
);
  logic [1:0] committed;
  logic [1:0] volat;

  // Only the factory init clears it; nrst leaves it alone
  always_ff @(posedge clk or negedge nvInitN) begin
    if (!nvInitN) begin
      committed <= 2'h0;
    end else if (saveReq) begin
      committed <= level;
    end
  end

  // Unsaved tightening is lost at reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      volat <= 2'h0;
    end else if (setReq && setOk) begin
      volat <= newLevel;
    end
  end

  // Stricter of the two always applies
  assign level = fepp_pkg::fepp_level_t'((committed > volat) ? committed
                                                             : volat);
  assign setOk = (level != fepp_pkg::prot_level_xo) &&
                 (newLevel >= level) &&
                 (newLevel != 2'h3);

  never_relax_a: assert property (@(posedge clk) disable iff (!nrst)
    level >= $past(level))
    else $error("protection level became less strict");
  save_commit_a: assert property (@(posedge clk) disable iff (!nrst)
    saveReq |=> committed == $past(level))
    else $error("save did not commit current level");
endmodule // fepp_prot_cell

// *** core/fepp_flash_ctrl.sv ***
// Flash controller: erase, program, block protection and interrupt status
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "fepp_defs.svh"

module fepp_flash_ctrl (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 nvInitN,
  input  wire logic [7:0]           regAddr,
  input  wire logic [31:0]          regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [31:0]          regRdata,
  input  wire logic                 arrRd,
  input  fepp_pkg::fepp_rdreq_t     arrReq,
  output logic      [31:0]          arrRdata,
  output logic                      arrDenied,
  output logic                      irq
);
  typedef enum logic {ST_IDLE, ST_BUSY} fepp_state_t;

  fepp_state_t               state;
  logic [`FEPP_FADDR_W-1:0]  faddr;
  logic [31:0]               wdata;
  logic [7:0]                usec;
  logic                      fail;
  fepp_pkg::fepp_level_t     plevel;
  fepp_pkg::fepp_ints_t      intRaw;
  fepp_pkg::fepp_ints_t      intEn;
  fepp_pkg::fepp_ints_t      intSet;
  logic [31:0]               mem [`FEPP_WORDS];
  logic                      opErase;
  logic [9:0]                opWord;
  logic [31:0]               opData;
  fepp_pkg::fepp_level_t     lvl [`FEPP_NUM_PBLK];
  logic [`FEPP_NUM_PBLK-1:0] setOk;
  logic [`FEPP_NUM_PBLK-1:0] setSel;
  logic                      wrCmd;
  logic                      cmdProg;
  logic                      cmdErase;
  logic                      cmdPset;
  logic                      cmdPsave;
  logic                      addrInRange;
  logic                      pblk;
  fepp_pkg::fepp_level_t     curLevel;
  logic                      progBad;
  logic                      eraseBad;
  logic                      psetBad;
  logic                      startOp;
  logic                      reject;
  logic                      tmrBusy;
  logic                      tmrDone;
  logic                      rdDeny;
  logic [7:0]                opUsecs;

  // Command decode, one command per write in priority order
  assign wrCmd    = regWr && (regAddr == `FEPP_REG_CMD);
  assign cmdProg  = wrCmd && regWdata[`FEPP_CMD_PROG];
  assign cmdErase = wrCmd && !cmdProg && regWdata[`FEPP_CMD_ERASE];
  assign cmdPset  = wrCmd && !regWdata[`FEPP_CMD_PROG] &&
                    !regWdata[`FEPP_CMD_ERASE] && regWdata[`FEPP_CMD_PSET];
  assign cmdPsave = wrCmd && (regWdata[2:0] == 3'h0) &&
                    regWdata[`FEPP_CMD_PSAVE];

  assign addrInRange = (faddr[15:12] == 4'h0);
  assign pblk        = faddr[11];
  assign curLevel    = lvl[pblk];

  // Program and erase only on read/write blocks
  assign progBad  = !addrInRange || (faddr[1:0] != 2'h0) ||
                    (curLevel != fepp_pkg::prot_level_rw);
  assign eraseBad = !addrInRange || (faddr[9:0] != 10'h000) ||
                    (curLevel != fepp_pkg::prot_level_rw);
  assign psetBad  = !addrInRange || !setOk[pblk];

  assign startOp = (state == ST_IDLE) &&
                   ((cmdProg && !progBad) ||
                    (cmdErase && !eraseBad));
  assign reject  = (state == ST_IDLE) &&
                   ((cmdProg && progBad) || (cmdErase && eraseBad) ||
                    (cmdPset && psetBad));
  assign opUsecs = cmdErase ? `FEPP_ERASE_TIME_US : `FEPP_PROG_TIME_US;

  // Configuration registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      faddr  <= '0;
      wdata  <= 32'h00000000;
      usec   <= `FEPP_USEC_RST;
      plevel <= fepp_pkg::prot_level_rw;
      intEn  <= '0;
    end else if (regWr) begin
      case (regAddr)
        `FEPP_REG_ADDR:   faddr  <= regWdata[`FEPP_FADDR_W-1:0];
        `FEPP_REG_WDATA:  wdata  <= regWdata;
        `FEPP_REG_USEC:   usec   <= regWdata[7:0];
        `FEPP_REG_PLEVEL: plevel <= fepp_pkg::fepp_level_t'(regWdata[1:0]);
        `FEPP_REG_INTEN:  intEn  <= fepp_pkg::fepp_ints_t'(regWdata[1:0]);
        default: ;
      endcase
    end
  end

  // Protect-set reaches only the block that the address selects
  always_comb begin
    for (int k = 0; k < `FEPP_NUM_PBLK; k++) begin
      setSel[k] = cmdPset && (state == ST_IDLE) && addrInRange &&
                  (pblk == 1'(k));
    end
  end

  // Per-block protection cells
  genvar gi;
  generate
    for (gi = 0; gi < `FEPP_NUM_PBLK; gi++) begin : gProt
      fepp_prot_cell uCell (
        .clk      (clk),
        .nrst     (nrst),
        .nvInitN  (nvInitN),
        .setReq   (setSel[gi]),
        .newLevel (plevel),
        .saveReq  (cmdPsave && (state == ST_IDLE)),
        .level    (lvl[gi]),
        .setOk    (setOk[gi])
      );
    end
  endgenerate

  fepp_usec_timer uTimer (
    .clk       (clk),
    .nrst      (nrst),
    .start     (startOp),
    .usecs     (opUsecs),
    .clksPerUs (usec),
    .busy      (tmrBusy),
    .done      (tmrDone)
  );

  // Operation sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state   <= ST_IDLE;
      opErase <= 1'b0;
      opWord  <= 10'h000;
      opData  <= 32'h00000000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (startOp) begin
            state   <= ST_BUSY;
            opErase <= cmdErase;
            opWord  <= faddr[11:2];
            opData  <= wdata;
          end
        end
        ST_BUSY: begin
          if (tmrDone) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fail <= 1'b0;
    end else if (reject) begin
      fail <= 1'b1;
    end else if (startOp || ((cmdPset || cmdPsave) && state == ST_IDLE)) begin
      fail <= 1'b0;
    end
  end

  // Array cells, nonvolatile: only the factory init resets them, nrst does not
  always_ff @(posedge clk or negedge nvInitN) begin
    if (!nvInitN) begin
      for (int i = 0; i < `FEPP_WORDS; i++) begin
        mem[i] <= `FEPP_ERASED_WORD;
      end
    end else if (tmrDone && state == ST_BUSY) begin
      if (opErase) begin
        for (int i = 0; i < `FEPP_EBLK_WORDS; i++) begin
          mem[{opWord[9:8], i[7:0]}] <= `FEPP_ERASED_WORD;
        end
      end else begin
        // Programming only pulls ones to zeros
        mem[opWord] <= mem[opWord] & opData;
      end
    end
  end

  // Read and fetch port
  assign rdDeny = arrRd && !arrReq.fetch &&
                  (lvl[arrReq.addr[11]] == fepp_pkg::prot_level_xo);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arrRdata  <= 32'h00000000;
      arrDenied <= 1'b0;
    end else begin
      arrDenied <= rdDeny;
      if (arrRd) begin
        arrRdata <= rdDeny ? 32'h00000000 : mem[arrReq.addr[11:2]];
      end
    end
  end

  // Interrupt sources; a new event wins over a clear
  assign intSet = '{access: reject || rdDeny,
                    done:   tmrDone && (state == ST_BUSY)};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      intRaw <= '0;
    end else if (regWr && regAddr == `FEPP_REG_INTCLR) begin
      intRaw <= (intRaw & ~fepp_pkg::fepp_ints_t'(regWdata[1:0])) |
                intSet;
    end else begin
      intRaw <= intRaw | intSet;
    end
  end

  assign irq = |(intRaw & intEn);

  // Register read data, valid the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        `FEPP_REG_ADDR:   regRdata <= {16'h0000, faddr};
        `FEPP_REG_WDATA:  regRdata <= wdata;
        `FEPP_REG_CMD:    regRdata <= {30'h0, fail, state == ST_BUSY};
        `FEPP_REG_PLEVEL: regRdata <= {30'h0, curLevel};
        `FEPP_REG_USEC:   regRdata <= {24'h0, usec};
        `FEPP_REG_INTRAW: regRdata <= {30'h0, intRaw};
        `FEPP_REG_INTMSK: regRdata <= {30'h0, intRaw & intEn};
        `FEPP_REG_INTEN:  regRdata <= {30'h0, intEn};
        default:          regRdata <= 32'h00000000;
      endcase
    end
  end

  sequence sEraseDone;
    tmrDone && state == ST_BUSY && opErase;
  endsequence

  sequence sRefusedErase;
    cmdErase && state == ST_IDLE &&
      curLevel != fepp_pkg::prot_level_rw;
  endsequence

  erase_fill_a: assert property (@(posedge clk) disable iff (!nrst)
    sEraseDone |=> mem[{opWord[9:8], 8'hff}] == `FEPP_ERASED_WORD &&
                   mem[{opWord[9:8], 8'h00}] == `FEPP_ERASED_WORD)
    else $error("erased block not all ones");
  erase_refuse_a: assert property (@(posedge clk) disable iff (!nrst)
    sRefusedErase |=> state == ST_IDLE && fail && intRaw.access)
    else $error("protected block erase not refused");
  bad_addr_a: assert property (@(posedge clk) disable iff (!nrst)
    (cmdErase && state == ST_IDLE && !addrInRange) |=> fail ##1 !tmrBusy)
    else $error("invalid erase address not failed");
  int_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (regWr && regAddr == `FEPP_REG_INTCLR && regWdata[1:0] == 2'h3 &&
     intSet == 2'h0) |=> intRaw == 2'h0 && !irq)
    else $error("interrupt clear ineffective");
  irq_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    (intEn == 2'h0) |-> !irq)
    else $error("disabled source drives interrupt");
  masked_view_a: assert property (@(posedge clk) disable iff (!nrst)
    (regRd && regAddr == `FEPP_REG_INTMSK) |=>
      regRdata[1:0] == ($past(intRaw) & $past(intEn)))
    else $error("masked status read wrong");
  done_event_a: assert property (@(posedge clk) disable iff (!nrst)
    (tmrDone && state == ST_BUSY) |=> intRaw.done && state == ST_IDLE)
    else $error("completion not flagged");
  ro_prog_a: assert property (@(posedge clk) disable iff (!nrst)
    (cmdProg && state == ST_IDLE && curLevel == fepp_pkg::prot_level_ro)
      |=> state == ST_IDLE [*2])
    else $error("program started on read-only block");
  xo_deny_a: assert property (@(posedge clk) disable iff (!nrst)
    rdDeny |=> arrDenied && arrRdata == 32'h00000000 && intRaw.access)
    else $error("execute-only data read not denied");

  sequence sProgDone;
    tmrDone && state == ST_BUSY && !opErase;
  endsequence

  sequence sPsetTaken;
    cmdPset && state == ST_IDLE && !psetBad;
  endsequence

  sequence sDataRead;
    arrRd && lvl[arrReq.addr[11]] != fepp_pkg::prot_level_xo;
  endsequence

  prog_and_a: assert property (@(posedge clk) disable iff (!nrst)
    sProgDone |=> mem[$past(opWord)] == $past(mem[opWord] & opData))
    else $error("programmed word not combined with data");
  start_busy_a: assert property (@(posedge clk) disable iff (!nrst)
    startOp |=> state == ST_BUSY && tmrBusy)
    else $error("accepted operation not started");
  access_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    reject |=> fail && intRaw.access)
    else $error("refused command not flagged");
  raw_view_a: assert property (@(posedge clk) disable iff (!nrst)
    (regRd && regAddr == `FEPP_REG_INTRAW) |=>
      regRdata[1:0] == $past(intRaw))
    else $error("raw status read wrong");
  relax_deny_a: assert property (@(posedge clk) disable iff (!nrst)
    (cmdPset && state == ST_IDLE && addrInRange && plevel < curLevel) |=>
      fail && curLevel == $past(curLevel))
    else $error("protection level relaxed");
  xo_frozen_a: assert property (@(posedge clk) disable iff (!nrst)
    (cmdPset && state == ST_IDLE && curLevel == fepp_pkg::prot_level_xo) |=>
      fail && curLevel == fepp_pkg::prot_level_xo)
    else $error("execute-only block altered");
  pset_apply_a: assert property (@(posedge clk) disable iff (!nrst)
    sPsetTaken |=> curLevel == $past(plevel) && !fail)
    else $error("protection level not applied");
  fetch_allow_a: assert property (@(posedge clk) disable iff (!nrst)
    (arrRd && arrReq.fetch) |=> !arrDenied)
    else $error("instruction fetch denied");
  data_read_a: assert property (@(posedge clk) disable iff (!nrst)
    sDataRead |=> !arrDenied && arrRdata == $past(mem[arrReq.addr[11:2]]))
    else $error("permitted data read wrong");
  save_ok_a: assert property (@(posedge clk) disable iff (!nrst)
    (cmdPsave && state == ST_IDLE) |=> !fail)
    else $error("protection save reported failure");
  prog_refuse_a: assert property (@(posedge clk) disable iff (!nrst)
    (cmdProg && state == ST_IDLE && progBad) |=> fail ##1 !tmrBusy)
    else $error("refused program started");
  fail_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (state == ST_BUSY) |=> $stable(fail))
    else $error("status changed while busy");
endmodule // fepp_flash_ctrl

// *** verif/fepp_cpu_model.sv ***
// Bus master model of the processor side of the flash controller
`timescale 1ns/1ps
`include "fepp_defs.svh"
module fepp_cpu_model (
  input  wire logic             clk,
  input  wire logic      [31:0] regRdata,
  input  wire logic      [31:0] arrRdata,
  input  wire logic             arrDenied,
  output logic           [7:0]  regAddr,
  output logic           [31:0] regWdata,
  output logic                  regWr,
  output logic                  regRd,
  output logic                  arrRd,
  output fepp_pkg::fepp_rdreq_t arrReq
);
  logic [1023:0] progUsed;

  initial begin
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    arrRd = 1'b0;
    arrReq = '0;
    progUsed = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
    regWdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    // Taken mid-cycle while the read data stand
    @(negedge clk);
    d = regRdata;
  endtask

  task automatic ard(input logic f, input logic g, input logic [11:0] a,
                     output logic [31:0] d, output logic den);
    @(posedge clk);
    arrReq <= '{fetch: f, debug: g, addr: a};
    arrRd  <= 1'b1;
    @(posedge clk);
    arrRd  <= 1'b0;
    @(negedge clk);
    d = arrRdata;
    den = arrDenied;
  endtask

  // Address, data and command, then poll busy
  task automatic op(input logic [15:0] a, input logic [31:0] d,
                    input logic [3:0] c, output logic [31:0] sts);
    int n;
    if (c[0] && progUsed[a[11:2]]) c = 4'h0;
    wr(`FEPP_REG_ADDR, {16'h0000, a[15:2], 2'b00});
    wr(`FEPP_REG_WDATA, d);
    wr(`FEPP_REG_CMD, {28'h0, c});
    sts = 32'h1;
    for (n = 0; n < 64 && sts[0]; n++) begin
      rd(`FEPP_REG_CMD, sts);
    end
    if (c[0]) progUsed[a[11:2]] = 1'b1;
    if (c[1] && !sts[1]) progUsed[{a[11:10], 8'h00} +: 256] = '0;
  endtask
endmodule // fepp_cpu_model

// *** verif/fepp_testbench.sv ***
// Self-checking bench for the flash erase, program and protection block
`timescale 1ns/1ps
`include "fepp_defs.svh"
module testbench;
  logic                  clk;
  logic                  nrst;
  logic                  nvInitN;
  logic [7:0]            regAddr;
  logic [31:0]           regWdata;
  logic                  regWr;
  logic                  regRd;
  logic [31:0]           regRdata;
  logic                  arrRd;
  fepp_pkg::fepp_rdreq_t arrReq;
  logic [31:0]           arrRdata;
  logic                  arrDenied;
  logic                  irq;
  logic [31:0]           s;
  int                    failures;
  int                    checkCount;
  int                    cycles;

  fepp_flash_ctrl u_dut (.clk(clk), .nrst(nrst), .nvInitN(nvInitN),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .arrRd(arrRd), .arrReq(arrReq),
    .arrRdata(arrRdata), .arrDenied(arrDenied), .irq(irq));
  fepp_cpu_model u_cpu (.clk(clk), .regRdata(regRdata),
    .arrRdata(arrRdata), .arrDenied(arrDenied), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .arrRd(arrRd),
    .arrReq(arrReq));

  always #2.5 clk = ~clk;

  task automatic results();
    if (failures == 0 && checkCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("ERROR %0t: run too long", $time);
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    u_cpu.rd(a, d);
    chk(d, e);
  endtask

  task automatic arrChk(input logic f, input logic g, input logic [11:0] a,
                        input logic [31:0] e, input logic den);
    logic [31:0] d;
    logic        dn;
    u_cpu.ard(f, g, a, d, dn);
    chk(d, e);
    chkBit(dn, den);
  endtask

  task automatic doReset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
  endtask

  task automatic tDefaults();
    rdChk(`FEPP_REG_INTRAW, 32'h0);
    rdChk(`FEPP_REG_INTEN, 32'h0);
    rdChk(`FEPP_REG_USEC, 32'h1);
    rdChk(8'h24, 32'h0);
    rdChk(`FEPP_REG_CMD, 32'h0);
    chkBit(irq, 1'b0);
  endtask

  task automatic tProgram();
    u_cpu.wr(`FEPP_REG_USEC, 32'h1);
    u_cpu.op(16'h0000, 32'h1234_5678, 4'h1, s);
    chk(s, 32'h0);
    arrChk(1'b0, 1'b0, 12'h000, 32'h1234_5678, 1'b0);
    rdChk(`FEPP_REG_INTRAW, 32'h1);
    rdChk(`FEPP_REG_INTMSK, 32'h0);
    chkBit(irq, 1'b0);
    u_cpu.wr(`FEPP_REG_INTEN, 32'h1);
    rdChk(`FEPP_REG_INTMSK, 32'h1);
    chkBit(irq, 1'b1);
    u_cpu.wr(`FEPP_REG_INTCLR, 32'h1);
    rdChk(`FEPP_REG_INTRAW, 32'h0);
    chkBit(irq, 1'b0);
  endtask

  task automatic tErase();
    u_cpu.op(16'h0400, 32'h0000_ffff, 4'h1, s);
    u_cpu.op(16'h0000, 32'h0, 4'h2, s);
    chk(s, 32'h0);
    arrChk(1'b0, 1'b0, 12'h000, `FEPP_ERASED_WORD, 1'b0);
    arrChk(1'b0, 1'b0, 12'h3fc, `FEPP_ERASED_WORD, 1'b0);
    arrChk(1'b0, 1'b0, 12'h400, 32'h0000_ffff, 1'b0);
  endtask

  task automatic tBadErase();
    u_cpu.wr(`FEPP_REG_INTCLR, 32'h3);
    u_cpu.op(16'h0004, 32'h0, 4'h2, s);
    chk(s, 32'h2);
    rdChk(`FEPP_REG_INTRAW, 32'h2);
    u_cpu.op(16'h1000, 32'h0, 4'h2, s);
    chk(s, 32'h2);
    u_cpu.wr(`FEPP_REG_INTCLR, 32'h3);
  endtask

  task automatic pset(input logic [31:0] lvl, input logic [31:0] e);
    u_cpu.wr(`FEPP_REG_PLEVEL, lvl);
    u_cpu.op(16'h0800, 32'h0, 4'h4, s);
    chk(s, e);
  endtask

  task automatic tProtect();
    u_cpu.op(16'h0804, 32'h00aa_00aa, 4'h1, s);
    pset(32'h1, 32'h0);
    rdChk(`FEPP_REG_PLEVEL, 32'h1);
    u_cpu.op(16'h0808, 32'h0, 4'h1, s);
    chk(s, 32'h2);
    arrChk(1'b0, 1'b0, 12'h808, `FEPP_ERASED_WORD, 1'b0);
    u_cpu.op(16'h0800, 32'h0, 4'h2, s);
    chk(s, 32'h2);
    arrChk(1'b0, 1'b0, 12'h804, 32'h00aa_00aa, 1'b0);
    pset(32'h0, 32'h2);
    rdChk(`FEPP_REG_PLEVEL, 32'h1);
    pset(32'h2, 32'h0);
    arrChk(1'b0, 1'b0, 12'h804, 32'h0, 1'b1);
    arrChk(1'b0, 1'b1, 12'h804, 32'h0, 1'b1);
    arrChk(1'b1, 1'b0, 12'h804, 32'h00aa_00aa, 1'b0);
    pset(32'h1, 32'h2);
    rdChk(`FEPP_REG_PLEVEL, 32'h2);
  endtask

  task automatic tVolatile();
    doReset();
    u_cpu.wr(`FEPP_REG_ADDR, 32'h800);
    rdChk(`FEPP_REG_PLEVEL, 32'h0);
    arrChk(1'b0, 1'b0, 12'h804, 32'h00aa_00aa, 1'b0);
    u_cpu.op(16'h0800, 32'h0, 4'h2, s);
    chk(s, 32'h0);
    arrChk(1'b0, 1'b0, 12'h804, `FEPP_ERASED_WORD, 1'b0);
  endtask

  task automatic tSave();
    pset(32'h1, 32'h0);
    u_cpu.op(16'h0800, 32'h0, 4'h8, s);
    chk(s, 32'h0);
    doReset();
    u_cpu.wr(`FEPP_REG_ADDR, 32'h800);
    rdChk(`FEPP_REG_PLEVEL, 32'h1);
    pset(32'h0, 32'h2);
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    nvInitN = 1'b0;
    failures = 0;
    checkCount = 0;
    cycles = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    nvInitN <= 1'b1;
    tDefaults();
    tProgram();
    tErase();
    tBadErase();
    tProtect();
    tVolatile();
    tSave();
    results();
  end
endmodule // testbench
